// ---- rtl/qbw_pkg.sv ----
// shared constants for the quad byte write link: nibble codes, cycle counts
// assumes both ends run on one clock and share the nibble bus through qbw_if
package qbw_pkg;
   localparam logic [3:0] START_WRITE   = 4'hE;  // cycle start code
   localparam logic [3:0] SIZE_QUAD     = 4'h2;  // four byte transfer size
   localparam logic [3:0] TAR_NIBBLE    = 4'hF;  // turnaround level
   localparam logic [3:0] SYNC_OK       = 4'h0;  // acknowledge code
   localparam int         ADDR_NIBBLES  = 7;     // 28 bit address
   localparam int         DATA_NIBBLES  = 8;     // four bytes, two nibbles each
   localparam int         ADDR_W        = 28;
   localparam int         LOW_ADDR_BITS = 2;     // dropped for quad alignment
   localparam logic [3:0] ID_RESET      = 4'h0;  // reset value of strap latch
   typedef enum logic [1:0] {QBW_CMD_NONE, QBW_CMD_PROG4} qbw_cmd_t;
endpackage

// ---- rtl/qbw_if.sv ----
// the shared nibble bus and frame strobe between host end and target end
// assumes the bench resolves the bus level from the two output enables
`timescale 1ns/1ps
`default_nettype none
interface qbw_if;
   logic       frameStrobeN;  // low while the host drives the start nibble
   logic [3:0] hostNibble;    // host drive value
   logic       hostOe;        // host drives nibble bus
   logic [3:0] devNibble;     // target drive value
   logic       devOe;         // target drives nibble bus
   logic [3:0] nibbleBus;     // resolved bus level, driven by the bench
   modport host (output frameStrobeN, output hostNibble, output hostOe,
                 input nibbleBus);
   modport dev  (input frameStrobeN, input nibbleBus,
                 output devNibble, output devOe);
endinterface
`default_nettype wire

// ---- rtl/qbw_target.sv ----
// target end of the nibble bus: decodes quad byte writes, answers with sync
// assumes bus and strobe come from pins (double synchronised here) and the
// command interpreter beyond accepts one write per cycle pulse
// How it works
// - start nibble 1110b with strobe low begins
// - id nibble must equal the straps
// - seven address nibbles, most significant first
// - two lowest address bits forced to zero
// - size nibble 0010b marks four bytes
// - eight data nibbles, low nibble first
// - bytes fill offsets 00 to 11 in order
// - host drives 1111b in cycle 19
// - cycle 20 host releases, bus floats until cycle 23
// - target drives sync 0000b in cycle 23
// - target drives 1111b in cycle 24
// - target floats bus in cycle 25
// - every accepted write goes to the interpreter
// - program write latches address and all bytes
`timescale 1ns/1ps
`default_nettype none
module qbw_target
   import qbw_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                reset,
   qbw_if.dev                       bus,
   input  wire logic [3:0]          idStrapIn,
   output logic                     writeValid,
   output logic [ADDR_W-1:0]        writeAddr,
   output logic [31:0]              writeData,
   output logic                     writeMatched
);
   typedef enum logic [3:0] {
      S_IDLE, S_ID, S_ADDR, S_SIZE, S_DATA, S_TAR_HOST, S_TAR_TAKE, S_SYNC,
      S_TAR_DEV, S_SKIP
   } qbw_tgt_state_t;

   qbw_tgt_state_t   state_r;
   logic [3:0]       nib_r;
   logic             frmN_r;
   logic [3:0]       idStrap_r;
   logic [3:0]       cnt_r;
   logic [ADDR_W-1:0] addr_r;
   logic [31:0]      data_r;
   logic             selected_r;

   ////////////////////////////////////////////////////////////////////////////
   // pin inputs pass two flops; latency is uniform so the frame still lines up
   // reset loads the idle bus level so no false start follows reset
   qbw_sync2 #(
      .WIDTH     (4),
      .RESET_VAL (TAR_NIBBLE)
   ) nibSync (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (bus.nibbleBus),
      .dout     (nib_r)
   );

   // frame strobe idles high, so its stages reset high as well
   qbw_sync2 #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   ) frmSync (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (bus.frameStrobeN),
      .dout     (frmN_r)
   );

   // straps are pins too; a strap change takes two cycles to count
   qbw_sync2 #(
      .WIDTH     (4),
      .RESET_VAL (ID_RESET)
   ) strapSync (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (idStrapIn),
      .dout     (idStrap_r)
   );

   ////////////////////////////////////////////////////////////////////////////
   // cycle sequencer; a frame restart always wins so a stuck frame recovers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r    <= S_IDLE;
         cnt_r      <= 4'h0;
         selected_r <= 1'b0;
      end else if (!frmN_r && nib_r == START_WRITE) begin
         state_r <= S_ID;
      end else begin
         case (state_r)
            S_IDLE: state_r <= S_IDLE;
            S_ID: begin
               selected_r <= (nib_r == idStrap_r);
               cnt_r      <= 4'h0;
               state_r    <= S_ADDR;
            end
            S_ADDR: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(ADDR_NIBBLES - 1)) begin
                  state_r <= S_SIZE;
               end
            end
            S_SIZE: begin
               cnt_r <= 4'h0;
               // other sizes are not ours; sit out without driving
               state_r <= (nib_r == SIZE_QUAD) ? S_DATA : S_IDLE;
            end
            S_DATA: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(DATA_NIBBLES - 1)) begin
                  state_r <= S_TAR_HOST;
               end
            end
            S_TAR_HOST: begin
               // an unselected target sits out the answer cycles
               state_r <= selected_r ? S_TAR_TAKE : S_SKIP;
            end
            S_TAR_TAKE: begin
               state_r <= S_SYNC;
            end
            S_SYNC: begin
               state_r <= S_TAR_DEV;
            end
            S_TAR_DEV: begin
               state_r <= S_IDLE;
            end
            S_SKIP: begin
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address shifter and indexed data nibble register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         addr_r <= '0;
         data_r <= '0;
      end else begin
         if (state_r == S_ADDR) begin
            addr_r <= {addr_r[ADDR_W-5:0], nib_r};
         end
         if (state_r == S_DATA) begin
            // even count low nibble, odd high; byte index is count/2
            data_r[{cnt_r[2:0], 2'b00} +: 4] <= nib_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hand-off to interpreter: whole write latched at once at sync time
   always_ff @(posedge core_clk) begin
      if (reset) begin
         writeValid   <= 1'b0;
         writeAddr    <= '0;
         writeData    <= '0;
         writeMatched <= 1'b0;
      end else begin
         writeValid <= (state_r == S_TAR_TAKE);
         if (state_r == S_TAR_TAKE) begin
            writeAddr <= {addr_r[ADDR_W-1:LOW_ADDR_BITS], 2'b00};
            writeData <= data_r;
         end
         writeMatched <= selected_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus drive: only when selected, sync then turnaround; float otherwise
   always_comb begin
      bus.devOe     = 1'b0;
      bus.devNibble = TAR_NIBBLE;
      case (state_r)
         S_SYNC: begin
            bus.devOe     = 1'b1;
            bus.devNibble = SYNC_OK;
         end
         S_TAR_DEV: begin
            bus.devOe     = 1'b1;
            bus.devNibble = TAR_NIBBLE;
         end
         default: bus.devOe = 1'b0;
      endcase
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// two flop synchroniser; only the second stage may be read by logic
module qbw_sync2 #(
   parameter int               WIDTH     = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r;

   // both stages load the idle level so no edge appears out of reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_r <= RESET_VAL;
         dout   <= RESET_VAL;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/qbw_host.sv ----
// host end: issues one quad byte write frame per request, waits for sync
// assumes the target answers sync on the cycle the frame table gives
`timescale 1ns/1ps
`default_nettype none
module qbw_host
   import qbw_pkg::*;
#(
   parameter int SYNC_WAIT = 8  // cycles to wait for sync before giving up
)(
   input  wire logic              core_clk,
   input  wire logic              reset,
   qbw_if.host                    bus,
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire logic [3:0]        reqId,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [31:0]       reqData,
   output logic                   doneValid,
   output logic                   doneAck
);
   typedef enum logic [2:0] {H_IDLE, H_ID, H_ADDR, H_SIZE, H_DATA, H_TAR, H_WAIT}
      qbw_host_state_t;
   qbw_host_state_t   state_r;
   logic [3:0]        cnt_r, id_r;
   logic [ADDR_W-1:0] addr_r;
   logic [31:0]       data_r;
   logic [3:0]        nibMeta_r, nib_r;
   logic              syncSeen;

   // bus read back is a pin: two flops before use
   always_ff @(posedge core_clk) begin
      nibMeta_r <= bus.nibbleBus;
      nib_r     <= nibMeta_r;
   end

   // the first two wait cycles still show our own nibbles through the
   // synchroniser, so a zero data nibble there must not pass for sync
   assign syncSeen = (cnt_r >= 4'h2) && (nib_r == SYNC_OK);

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r   <= H_IDLE;
         cnt_r     <= 4'h0;
         id_r      <= 4'h0;
         addr_r    <= '0;
         data_r    <= '0;
         doneValid <= 1'b0;
         doneAck   <= 1'b0;
      end else begin
         doneValid <= 1'b0;
         case (state_r)
            H_IDLE: begin
               if (reqValid) begin
                  id_r    <= reqId;
                  addr_r  <= reqAddr;
                  data_r  <= reqData;
                  state_r <= H_ID;
               end
            end
            H_ID: begin
               cnt_r   <= 4'h0;
               state_r <= H_ADDR;
            end
            H_ADDR: begin
               // count 0 carries the id, counts 1 to 7 the address nibbles
               if (cnt_r != 4'h0) begin
                  addr_r <= {addr_r[ADDR_W-5:0], 4'h0};
               end
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(ADDR_NIBBLES)) begin
                  state_r <= H_SIZE;
               end
            end
            H_SIZE: begin
               cnt_r   <= 4'h0;
               state_r <= H_DATA;
            end
            H_DATA: begin
               data_r <= {4'h0, data_r[31:4]};
               cnt_r  <= cnt_r + 4'h1;
               if (cnt_r == 4'(DATA_NIBBLES - 1)) begin
                  state_r <= H_TAR;
               end
            end
            H_TAR: begin
               cnt_r   <= 4'h0;
               state_r <= H_WAIT;
            end
            H_WAIT: begin
               // sync seen two flops late; bounded wait covers an absent target
               cnt_r <= cnt_r + 4'h1;
               if (syncSeen || cnt_r == 4'(SYNC_WAIT - 1)) begin
                  doneValid <= 1'b1;
                  doneAck   <= syncSeen;
                  state_r   <= H_IDLE;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive; host lets go after its turnaround so the target may drive
   always_comb begin
      reqReady         = (state_r == H_IDLE);
      bus.frameStrobeN = !(state_r == H_ID);
      bus.hostOe       = (state_r != H_WAIT);
      bus.hostNibble   = TAR_NIBBLE;
      case (state_r)
         H_ID:    bus.hostNibble = START_WRITE;
         H_ADDR:  bus.hostNibble = (cnt_r == 4'h0) ? id_r : addr_r[ADDR_W-1 -: 4];
         H_SIZE:  bus.hostNibble = SIZE_QUAD;
         H_DATA:  bus.hostNibble = data_r[3:0];
         H_TAR:   bus.hostNibble = TAR_NIBBLE;
         default: bus.hostNibble = TAR_NIBBLE;
      endcase
   end
endmodule
`default_nettype wire

// ---- dv/qbw_chk.sv ----
// checker for the nibble link between host end and target end
// assumes the signals of one qbw_if, one clock, sync active high reset
`timescale 1ns/1ps
`default_nettype none
module qbw_chk
   import qbw_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic       frameStrobeN,
   input wire logic [3:0] hostNibble,
   input wire logic       hostOe,
   input wire logic [3:0] devNibble,
   input wire logic       devOe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // frame steps; target may lag by its synchroniser, so its reply is tied to devOe
   sequence s_start;
      $fell(frameStrobeN) && hostOe;
   endsequence
   sequence s_dev_answer;
      devNibble == SYNC_OK ##1 devOe && devNibble == TAR_NIBBLE ##1 !devOe;
   endsequence
   sequence s_host_turn;
      hostOe && hostNibble == TAR_NIBBLE ##1 !hostOe;
   endsequence
   a_one_driver: assert property (!(hostOe && devOe))
      else $error("both ends drive the bus");
   a_start_code: assert property ($fell(frameStrobeN) |->
      hostOe && hostNibble == START_WRITE)
      else $error("frame start without start code");
   a_strobe_host: assert property (!frameStrobeN |-> hostOe)
      else $error("strobe low while host floats");
   a_size_code: assert property (s_start |-> ##9 hostNibble == SIZE_QUAD)
      else $error("size code wrong in cycle ten");
   a_host_turn: assert property (s_start |-> ##18 s_host_turn)
      else $error("host turnaround wrong");
   a_dev_reply: assert property ($rose(devOe) |-> s_dev_answer)
      else $error("target reply not sync then turnaround");
   a_dev_float: assert property ($rose(devOe) |-> ##2 !devOe [*3])
      else $error("target keeps driving after reply");
   a_dev_handover: assert property ($rose(devOe) |-> !$past(hostOe))
      else $error("target drives right after host");
   a_dev_values: assert property (devOe |->
      devNibble == SYNC_OK || devNibble == TAR_NIBBLE)
      else $error("target drives a stray nibble");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench: host end and target end joined by one qbw_if
// assumes the bench resolves the bus with a pull-up when nobody drives
`timescale 1ns/1ps
`default_nettype none
module tb
   import qbw_pkg::*;
;
   logic        core_clk, reset, reqValid, reqReady, doneValid, doneAck;
   logic        writeValid, writeMatched;
   logic [3:0]  reqId, idStrapIn;
   logic [27:0] reqAddr, writeAddr;
   logic [31:0] reqData, writeData;
   int          err_count, samples_checked, pulseCount;
   logic [3:0]  hostQ[$], devQ[$];
   bit          inFrame;
   qbw_if link();
   // pull-up level when both ends float
   assign link.nibbleBus = link.hostOe ? link.hostNibble : (link.devOe ? link.devNibble : 4'hF);
   qbw_host qbw_host_inst (.core_clk(core_clk), .reset(reset), .bus(link), .reqValid(reqValid),
      .reqReady(reqReady), .reqId(reqId), .reqAddr(reqAddr), .reqData(reqData),
      .doneValid(doneValid), .doneAck(doneAck));
   qbw_target qbw_target_inst (.core_clk(core_clk), .reset(reset), .bus(link),
      .idStrapIn(idStrapIn), .writeValid(writeValid), .writeAddr(writeAddr),
      .writeData(writeData), .writeMatched(writeMatched));
   qbw_chk qbw_chk_inst (.core_clk(core_clk), .reset(reset), .frameStrobeN(link.frameStrobeN),
      .hostNibble(link.hostNibble), .hostOe(link.hostOe), .devNibble(link.devNibble),
      .devOe(link.devOe));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, 50 ns period
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // wire monitor at the falling edge, where every output has settled;
   // host nibbles count only from frame start until the host lets go
   always @(negedge core_clk) begin
      if (!link.frameStrobeN) inFrame = 1'b1;
      if (inFrame && link.hostOe) hostQ.push_back(link.nibbleBus);
      if (!link.hostOe) inFrame = 1'b0;
      if (link.devOe) devQ.push_back(link.nibbleBus);
      if (writeValid) pulseCount++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // one frame, then the wire and the target outputs
   task automatic run_case(input logic [3:0] id, input logic [27:0] addr,
                           input logic [31:0] data, input logic hit);
      hostQ.delete();
      devQ.delete();
      pulseCount = 0;
      @(negedge core_clk);
      check("ready", 1, reqReady);
      reqId = id;
      reqAddr = addr;
      reqData = data;
      reqValid = 1'b1;
      @(negedge core_clk);
      reqValid = 1'b0;
      for (int n = 0; n < 80 && doneValid !== 1'b1; n++) @(negedge core_clk);
      check("done", 1, doneValid);
      check("ack", hit, doneAck);
      repeat (6) @(negedge core_clk);
      check("pulses", hit, pulseCount);
      check("matched", hit, writeMatched);
      check("dev cycles", hit ? 2 : 0, devQ.size());
      check("host cycles", 19, hostQ.size());
      if (hostQ.size() == 19) begin
         check("start", START_WRITE, hostQ[0]);
         check("id", id, hostQ[1]);
         for (int k = 0; k < 7; k++) check("addr nib", addr[27-4*k -: 4], hostQ[2+k]);
         check("size", SIZE_QUAD, hostQ[9]);
         for (int j = 0; j < 8; j++) check("data nib", data[4*j +: 4], hostQ[10+j]);
         check("host tar", TAR_NIBBLE, hostQ[18]);
      end
      if (hit && devQ.size() == 2) begin
         check("sync", SYNC_OK, devQ[0]);
         check("dev tar", TAR_NIBBLE, devQ[1]);
      end
      if (hit) begin
         check("addr", {addr[27:2], 2'b00}, writeAddr);
         check("data", data, writeData);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: match, mismatch, top address, new strap
   initial begin
      reqValid = 1'b0;
      reqId = 4'h0;
      reqAddr = 28'h0;
      reqData = 32'h0;
      idStrapIn = 4'h5;
      reset = 1'b1;
      repeat (10) @(negedge core_clk);
      reset = 1'b0;
      run_case(4'h5, 28'h1234567, 32'hA1B2C3D4, 1'b1);
      run_case(4'h3, 28'h0ABCDEF, 32'h11223344, 1'b0);
      check("kept data", 32'hA1B2C3D4, writeData);
      run_case(4'h5, 28'hFFFFFFF, 32'hFFEE0001, 1'b1);
      idStrapIn = 4'hA;
      run_case(4'hA, 28'h0000003, 32'h8040201F, 1'b1);
      close_out();
   end
   // watchdog: four frames need well under 400 cycles
   initial begin
      repeat (1000) @(posedge core_clk);
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
